//--- design/opvp_defines.svh
`ifndef OPVP_DEFINES_SVH
`define OPVP_DEFINES_SVH

// ****************************************************************
// Register map of the software view.
// ****************************************************************
`define OPVP_CTRL_OFS       32'h0000_0000
`define OPVP_STAT_OFS       32'h0000_0004
`define OPVP_CTRL_EN_BIT    0
`define OPVP_CTRL_RST       1'b1
`define OPVP_STAT_REF_BIT   4

// ****************************************************************
// Programming port constants.
// ****************************************************************
`define OPVP_PULSES         3'd5
`define OPVP_CODE_DEPTH     16384
`define OPVP_ENC_DEPTH      64
`define OPVP_ENC_LAST       14'h001f
`define OPVP_SIG0_ADDR      14'h0030
`define OPVP_SIG1_ADDR      14'h0031
`define OPVP_ERASED         8'hff

`endif

//--- design/opvp_pkg.sv
package opvp_pkg;

  typedef enum logic [2:0] {
    OPVP_IDLE,
    OPVP_READ_SIG,
    OPVP_VERIFY,
    OPVP_PGM_CODE,
    OPVP_PGM_ENC,
    OPVP_PGM_SB1,
    OPVP_PGM_SB2,
    OPVP_PGM_SB3
  } opvp_mode_t;

  typedef struct packed {
    logic        rst_pin;
    logic        program_store_enable_n;
    logic        latch_strobe_program_pulse;
    logic        external_access_program_supply;
    logic [1:0]  p2_hi;
    logic        port_three_bit_seven;
    logic        port_three_bit_six;
    logic [13:0] addr;
  } opvp_pins_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } opvp_wb_req_t;

endpackage

//--- design/opvp_pulse_train.sv
`timescale 1ns/1ps
`include "opvp_defines.svh"
module opvp_pulse_train (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       arm,
  input  wire logic       strobe,
  output logic            first_fall,
  output logic            commit,
  output logic [2:0]      count
);
  logic       prev_q;
  logic [2:0] cnt_q;
  logic       fall;
  logic       rise;

  assign fall       = arm && prev_q && !strobe;
  assign rise       = arm && !prev_q && strobe;
  assign first_fall = fall && (cnt_q == 3'd0);
  assign commit     = rise && (cnt_q == `OPVP_PULSES);
  assign count      = cnt_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= strobe;
    end
  end

  // Counts low pulses of one write; the train restarts when the mode drops.
  always_ff @(posedge sys_clk) begin
    if (rst || !arm) begin
      cnt_q <= 3'd0;
    end else if (commit) begin
      cnt_q <= 3'd0;
    end else if (fall && cnt_q != `OPVP_PULSES) begin
      cnt_q <= cnt_q + 3'd1;
    end
  end

  property p_count_bound;
    @(posedge sys_clk) disable iff (rst) cnt_q <= `OPVP_PULSES;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("pulse count above five");
endmodule

//--- design/opvp_port.sv
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "opvp_defines.svh"
module opvp_port #(
  parameter logic [7:0] SIG_MAKER = 8'h5a,
  parameter logic [7:0] SIG_PART  = 8'h3c
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire opvp_pkg::opvp_wb_req_t wb_req,
  output logic                       wb_ack,
  output logic [31:0]                wb_dat_o,
  input  wire opvp_pkg::opvp_pins_t  pins,
  input  wire logic [7:0]            p0_i,
  output logic [7:0]                 p0_o,
  output logic                       p0_oe,
  input  wire logic                  code_table_read_instruction,
  input  wire logic                  fetch_from_external,
  output logic                       code_table_read_allow,
  output logic                       external_exec_allow,
  output logic                       external_access_effective
);
  import opvp_pkg::*;

  // ****************************************************************
  // Mode decode from the control pin levels.
  // ****************************************************************
  function automatic opvp_mode_t decode_mode(input opvp_pins_t p);
    logic [3:0] lv;
    lv = {p.p2_hi, p.port_three_bit_seven, p.port_three_bit_six};
    decode_mode = OPVP_IDLE;
    if (p.rst_pin && !p.program_store_enable_n) begin
      if (lv == 4'b0000) begin
        decode_mode = OPVP_READ_SIG;
      end else if (lv == 4'b0011) begin
        decode_mode = OPVP_VERIFY;
      end else if (p.external_access_program_supply) begin
        if (lv == 4'b1011) begin
          decode_mode = OPVP_PGM_CODE;
        end else if (lv == 4'b1010) begin
          decode_mode = OPVP_PGM_ENC;
        end else if (lv == 4'b1111) begin
          decode_mode = OPVP_PGM_SB1;
        end else if (lv == 4'b1100) begin
          decode_mode = OPVP_PGM_SB2;
        end else if (lv == 4'b0100) begin
          decode_mode = OPVP_PGM_SB3;
        end
      end
    end
  endfunction

  logic [7:0]  code_mem [`OPVP_CODE_DEPTH];
  logic [7:0]  enc_mem  [`OPVP_ENC_DEPTH];
  logic [2:0]  sb_q;
  logic        enc_prog_q;
  logic        refused_q;
  logic        ctrl_en_q;
  logic        ea_latched_q;
  logic [13:0] addr_q;
  logic [7:0]  data_q;
  opvp_mode_t  mode_q;
  opvp_mode_t  live_mode;
  logic        arm;
  logic        first_fall;
  logic        commit;
  logic [2:0]  pulse_cnt;
  logic        is_pgm;
  logic        permit;
  logic        code_we;
  logic        enc_we;
  logic        verify_ok;
  logic [7:0]  p0_q;
  logic        p0_oe_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        wb_hit;

  assign live_mode = ctrl_en_q ? decode_mode(pins) : OPVP_IDLE;
  assign is_pgm    = live_mode inside {OPVP_PGM_CODE, OPVP_PGM_ENC, OPVP_PGM_SB1, OPVP_PGM_SB2, OPVP_PGM_SB3};
  assign arm       = is_pgm;

  opvp_pulse_train u_train (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .arm        (arm),
    .strobe     (pins.latch_strobe_program_pulse),
    .first_fall (first_fall),
    .commit     (commit),
    .count      (pulse_cnt)
  );

  // ****************************************************************
  // Capture of the write request at the first strobe fall.
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_q <= 14'h0000;
      data_q <= 8'h00;
      mode_q <= OPVP_IDLE;
    end else if (first_fall) begin
      addr_q <= pins.addr;
      data_q <= p0_i;
      mode_q <= live_mode;
    end
  end

  // ****************************************************************
  // Write permission against the lock state.
  // ****************************************************************
  always_comb begin
    permit = 1'b0;
    case (mode_q)
      OPVP_PGM_CODE: permit = (sb_q == 3'b000);
      OPVP_PGM_ENC:  permit = (sb_q == 3'b000) && (addr_q <= `OPVP_ENC_LAST);
      OPVP_PGM_SB1,
      OPVP_PGM_SB2,
      OPVP_PGM_SB3:  permit = 1'b1;
      default:       permit = 1'b0;
    endcase
  end

  assign code_we = commit && permit && (mode_q == OPVP_PGM_CODE);
  assign enc_we  = commit && permit && (mode_q == OPVP_PGM_ENC);

  always_ff @(posedge sys_clk) begin
    if (code_we) begin
      code_mem[addr_q] <= data_q;
    end
  end

  // The array is held erased by reset, standing in for its factory state.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < `OPVP_ENC_DEPTH; i++) begin
        enc_mem[i] <= `OPVP_ERASED;
      end
    end else if (enc_we) begin
      enc_mem[addr_q[5:0]] <= data_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enc_prog_q <= 1'b0;
    end else if (enc_we && data_q != `OPVP_ERASED) begin
      enc_prog_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sb_q <= 3'b000;
    end else if (commit && permit) begin
      case (mode_q)
        OPVP_PGM_SB1: sb_q[0] <= 1'b1;
        OPVP_PGM_SB2: sb_q[1] <= 1'b1;
        OPVP_PGM_SB3: sb_q[2] <= 1'b1;
        default:      sb_q    <= sb_q;
      endcase
    end
  end

  // ****************************************************************
  // Security effects on the running core.
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ea_latched_q <= pins.external_access_program_supply;
    end
  end

  assign external_access_effective = sb_q[0] ? ea_latched_q : pins.external_access_program_supply;
  assign code_table_read_allow     = !(sb_q[0] && code_table_read_instruction && fetch_from_external);
  assign external_exec_allow       = (sb_q != 3'b111);

  // ****************************************************************
  // Verify and signature read-out on port 0.
  // ****************************************************************
  assign verify_ok = !sb_q[1] && !sb_q[2];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p0_q    <= 8'h00;
      p0_oe_q <= 1'b0;
    end else if (live_mode == OPVP_VERIFY && verify_ok) begin
      p0_oe_q <= 1'b1;
      if (enc_prog_q) begin
        p0_q <= ~(code_mem[pins.addr] ^ enc_mem[pins.addr[5:0]]);
      end else begin
        p0_q <= code_mem[pins.addr];
      end
    end else if (live_mode == OPVP_READ_SIG) begin
      p0_oe_q <= 1'b1;
      if (pins.addr == `OPVP_SIG0_ADDR) begin
        p0_q <= SIG_MAKER;
      end else if (pins.addr == `OPVP_SIG1_ADDR) begin
        p0_q <= SIG_PART;
      end else begin
        p0_q <= 8'h00;
      end
    end else begin
      p0_oe_q <= 1'b0;
    end
  end

  assign p0_o  = p0_q;
  assign p0_oe = p0_oe_q;

  // ****************************************************************
  // Wishbone slave with control and status registers.
  // ****************************************************************
  assign wb_hit = wb_req.cyc && wb_req.stb && !ack_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_hit;
      if (wb_hit && wb_req.adr == `OPVP_CTRL_OFS) begin
        rdat_q <= {31'h0000_0000, ctrl_en_q};
      end else if (wb_hit && wb_req.adr == `OPVP_STAT_OFS) begin
        rdat_q <= {23'h00_0000, ea_latched_q, pulse_cnt, refused_q, enc_prog_q, sb_q};
      end else begin
        rdat_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_en_q <= `OPVP_CTRL_RST;
    end else if (wb_hit && wb_req.we && wb_req.sel[0] && wb_req.adr == `OPVP_CTRL_OFS) begin
      ctrl_en_q <= wb_req.dat[`OPVP_CTRL_EN_BIT];
    end
  end

  // A refused write is flagged; a new refusal wins over a clear.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      refused_q <= 1'b0;
    end else if (commit && !permit) begin
      refused_q <= 1'b1;
    end else if (wb_hit && wb_req.we && wb_req.sel[0] && wb_req.adr == `OPVP_STAT_OFS
                 && wb_req.dat[`OPVP_STAT_REF_BIT]) begin
      refused_q <= 1'b0;
    end
  end

  assign wb_ack   = ack_q;
  assign wb_dat_o = rdat_q;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  property p_commit_five;
    @(posedge sys_clk) disable iff (rst) commit |-> pulse_cnt == `OPVP_PULSES;
  endproperty
  a_commit_five: assert property (p_commit_five) else $error("commit before fifth pulse");

  property p_lock_code;
    @(posedge sys_clk) disable iff (rst) (code_we || enc_we) |-> sb_q == 3'b000;
  endproperty
  a_lock_code: assert property (p_lock_code) else $error("array written while locked");

  property p_sb_sticky;
    @(posedge sys_clk) disable iff (rst) ##1 (sb_q & $past(sb_q)) == $past(sb_q);
  endproperty
  a_sb_sticky: assert property (p_sb_sticky) else $error("security bit cleared");

  property p_sb_set;
    @(posedge sys_clk) disable iff (rst) (commit && mode_q == OPVP_PGM_SB2) |=> sb_q[1];
  endproperty
  a_sb_set: assert property (p_sb_set) else $error("security bit two not set");

  property p_verify_off;
    @(posedge sys_clk) disable iff (rst)
      (sb_q[1] && live_mode == OPVP_VERIFY) |=> !p0_oe;
  endproperty
  a_verify_off: assert property (p_verify_off) else $error("verify while disabled");

  property p_verify_on;
    @(posedge sys_clk) disable iff (rst)
      (verify_ok && live_mode == OPVP_VERIFY) |=> p0_oe;
  endproperty
  a_verify_on: assert property (p_verify_on) else $error("verify not driven");

  property p_sig_maker;
    @(posedge sys_clk) disable iff (rst)
      (live_mode == OPVP_READ_SIG && pins.addr == `OPVP_SIG0_ADDR) |=> (p0_oe && p0_o == SIG_MAKER);
  endproperty
  a_sig_maker: assert property (p_sig_maker) else $error("wrong maker signature");

  property p_ext_exec;
    @(posedge sys_clk) disable iff (rst) (sb_q == 3'b111) |-> !external_exec_allow;
  endproperty
  a_ext_exec: assert property (p_ext_exec) else $error("external execution allowed");

  property p_table_read;
    @(posedge sys_clk) disable iff (rst)
      (sb_q[0] && code_table_read_instruction && fetch_from_external) |-> !code_table_read_allow;
  endproperty
  a_table_read: assert property (p_table_read) else $error("external table read allowed");

  property p_ack_pulse;
    @(posedge sys_clk) disable iff (rst) wb_ack |=> !wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

  c_code_write: cover property (@(posedge sys_clk) disable iff (rst) code_we);
  c_sb_write:   cover property (@(posedge sys_clk) disable iff (rst) commit && mode_q == OPVP_PGM_SB1);
  c_enc_verify: cover property (@(posedge sys_clk) disable iff (rst) enc_prog_q && p0_oe);
endmodule

//--- tb/opvp_programmer.sv
`timescale 1ns/1ps
module opvp_programmer #(
  parameter int LOW_CYC  = 4,
  parameter int HIGH_CYC = 2
) (
  input  wire logic            sys_clk,
  output opvp_pkg::opvp_pins_t pins,
  output logic [7:0]           p0_i,
  input  wire logic [7:0]      p0_o,
  input  wire logic            p0_oe
);
  import opvp_pkg::*;
  logic       drv;
  logic [7:0] dat;

  // Port 0 has pull-ups, so a bus that nobody drives reads all ones.
  assign p0_i = p0_oe ? p0_o : (drv ? dat : 8'hff);

  initial begin
    pins = '{rst_pin: 1'b0, program_store_enable_n: 1'b1, latch_strobe_program_pulse: 1'b1, default: '0};
    drv  = 1'b0;
    dat  = 8'h00;
  end

  // ****************************************************************
  // Mode levels and pulse trains.
  // ****************************************************************
  task automatic set_mode(input logic [3:0] lv, input logic sup, input logic [13:0] a, input logic dv);
    pins <= '{rst_pin: 1'b1, program_store_enable_n: 1'b0, latch_strobe_program_pulse: 1'b1,
              external_access_program_supply: sup, p2_hi: lv[3:2], port_three_bit_seven: lv[1],
              port_three_bit_six: lv[0], addr: a};
    drv  <= dv;
  endtask

  // Pulse widths are scaled down; the block checks no minimum width.
  task automatic train(input logic [3:0] lv, input logic [13:0] a, input logic [7:0] d, input int n);
    set_mode(lv, 1'b1, a, 1'b1);
    dat <= d;
    repeat (2) @(posedge sys_clk);
    repeat (n) begin
      pins.latch_strobe_program_pulse <= 1'b0;
      repeat (LOW_CYC) @(posedge sys_clk);
      pins.latch_strobe_program_pulse <= 1'b1;
      repeat (HIGH_CYC) @(posedge sys_clk);
    end
  endtask
endmodule

//--- tb/opvp_port_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module opvp_port_tb;
  import opvp_pkg::*;
  // Signature values are arbitrary.
  localparam logic [7:0] MAKER = 8'h5a;
  localparam logic [7:0] PART  = 8'h3c;
  localparam logic [3:0] M_CODE = 4'b1011, M_TAB = 4'b1010, M_SB1 = 4'b1111, M_SB2 = 4'b1100;
  localparam logic [3:0] M_SB3 = 4'b0100, M_VER = 4'b0011, M_SIG = 4'b0000;
  logic         sys_clk, rst, cti, fetch, wb_ack, p0_oe, ct_allow, ex_allow, ea_eff;
  opvp_wb_req_t wb_req;
  opvp_pins_t   pins;
  logic [31:0]  wb_dat_o, rd;
  logic [7:0]   p0_i, p0_o;
  int           fails, num_checks, cycles;

  opvp_port #(.SIG_MAKER(MAKER), .SIG_PART(PART)) u_opvp_port (
    .sys_clk(sys_clk), .rst(rst), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
    .pins(pins), .p0_i(p0_i), .p0_o(p0_o), .p0_oe(p0_oe), .code_table_read_instruction(cti),
    .fetch_from_external(fetch), .code_table_read_allow(ct_allow), .external_exec_allow(ex_allow),
    .external_access_effective(ea_eff));

  opvp_programmer u_opvp_programmer (
    .sys_clk(sys_clk), .pins(pins), .p0_i(p0_i), .p0_o(p0_o), .p0_oe(p0_oe));

  // The clock keeps running through every programming operation.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // Bench tasks.
  // ****************************************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end

  task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    do @(posedge sys_clk); while (wb_ack !== 1'b1);
    rd = wb_dat_o;
    wb_req <= '0;
    @(posedge sys_clk);
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] ex, input string nm);
    wb(1'b0, a, 32'h0);
    `CHK(nm, ex, rd)
  endtask

  task automatic vchk(input logic [3:0] lv, input logic [13:0] a, input logic oe, input logic [7:0] ex);
    u_opvp_programmer.set_mode(lv, 1'b0, a, 1'b0);
    repeat (3) @(posedge sys_clk);
    `CHK("p0_oe", oe, p0_oe)
    if (oe) `CHK("p0_o", ex, p0_o)
  endtask

  task automatic pg(input logic [3:0] lv, input logic [13:0] a, input logic [7:0] d, input int n);
    u_opvp_programmer.train(lv, a, d, n);
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    rst = 1'b1;
    cti = 1'b1;
    fetch = 1'b1;
    wb_req = '0;
    fails = 0;
    num_checks = 0;
    cycles = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rchk(32'h4, 32'h0, "status");
    rchk(32'h0, 32'h1, "ctrl");
    rchk(32'h8, 32'h0, "unmapped");
    wb(1'b1, 32'h0, 32'h0);
    rchk(32'h0, 32'h0, "ctrl");
    vchk(M_SIG, 14'h0030, 1'b0, 8'h00);
    wb(1'b1, 32'h0, 32'h1);
    pg(M_CODE, 14'h0043, 8'ha5, 5);
    `CHK("ea_eff", 1'b1, ea_eff)
    `CHK("ct_allow", 1'b1, ct_allow)
    vchk(M_VER, 14'h0043, 1'b1, 8'ha5);
    pg(M_CODE, 14'h0044, 8'h3c, 5);
    pg(M_CODE, 14'h0044, 8'h00, 4);
    vchk(M_VER, 14'h0044, 1'b1, 8'h3c);
    vchk(M_SIG, 14'h0030, 1'b1, MAKER);
    vchk(M_SIG, 14'h0031, 1'b1, PART);
    vchk(M_SIG, 14'h0032, 1'b1, 8'h00);
    pg(M_TAB, 14'h0020, 8'h00, 5);
    rchk(32'h4, 32'h10, "status");
    wb(1'b1, 32'h4, 32'h10);
    rchk(32'h4, 32'h0, "status");
    pg(M_TAB, 14'h0003, 8'h0f, 5);
    rchk(32'h4, 32'h08, "status");
    vchk(M_VER, 14'h0043, 1'b1, 8'h55);
    vchk(M_VER, 14'h0044, 1'b1, 8'h3c);
    pg(M_SB1, 14'h0000, 8'h00, 5);
    `CHK("ea_eff", 1'b0, ea_eff)
    `CHK("ct_allow", 1'b0, ct_allow)
    fetch <= 1'b0;
    @(posedge sys_clk);
    `CHK("ct_allow", 1'b1, ct_allow)
    fetch <= 1'b1;
    rchk(32'h4, 32'h09, "status");
    pg(M_CODE, 14'h0043, 8'h00, 5);
    rchk(32'h4, 32'h19, "status");
    vchk(M_VER, 14'h0043, 1'b1, 8'h55);
    pg(M_TAB, 14'h0004, 8'h00, 5);
    vchk(M_VER, 14'h0044, 1'b1, 8'h3c);
    pg(M_SB2, 14'h0000, 8'h00, 5);
    rchk(32'h4, 32'h1b, "status");
    vchk(M_VER, 14'h0043, 1'b0, 8'h00);
    `CHK("ex_allow", 1'b1, ex_allow)
    pg(M_SB3, 14'h0000, 8'h00, 5);
    rchk(32'h4, 32'h1f, "status");
    `CHK("ex_allow", 1'b0, ex_allow)
    stop_test();
  end
endmodule
